/* core/hv_wake_input_logic.v */
// High-voltage wake input logic: edge filter, static/cyclic sense,
// wake flags, level status, pull selection, measurement gating and an
// AXI4-Lite register slave.
// Assumes the pin comparators are asynchronous and are synchronised here;
// the high-side switch on-time comes from timer logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "hv_wake_map.vh"

// Operation
// R1 - Both input edges count as wake events
// R2 - Interrupt in Normal/Stop, wake-up in Sleep/Fail-Safe
// R3 - Software selects static or cyclic sense
// R4 - Static sense filters input for 16 us
// R5 - Level must hold through filter window
// R6 - Software enable bit gates wake capability
// R7 - Pin wake sets flag in first status
// R8 - Live level readable in Normal/Stop/Init
// R9 - Cyclic sense reports last sampled level
// R10 - GPIO wake filtered, flagged in second status
// R11 - Pull select: none, pull-down, pull-up
// R12 - Select 1,1 follows input level automatically
// R13 - Cyclic: sample during switch on-time, compare
// R14 - Software sets GPIO as timer high-side switch
// R15 - Measurement disables fail output, GPIO, wake
// R16 - Measurement disables pulls, blocks wake signal
// R17 - Settings still stored while measurement enabled
// R18 - Measurement freezes status, level reads zero
// R19 - Sleep with only source: fail, Restart
// R20 - Interrupt drives low-active output for 100 us
// R21 - Filter is restartable counter to filter count
module hv_wake_input_logic #(
    parameter FILTER_CYCLES = `WAKE_FILTER_CYCLES, // Filter length in clocks
    parameter INT_CYCLES = `INT_PULSE_CYCLES // Interrupt pulse and gap in clocks
) (
    input wire mclk, // 100 MHz system clock
    input wire reset, // Synchronous reset, active high
    input wire hvWakePin, // Comparator output of the wake pin
    input wire gpioPin, // Comparator output of the GPIO pin
    input wire highSideSwitch, // Timer high-side switch on-time
    input wire [31:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output reg s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write strobes
    input wire s_axi_wvalid, // Write data valid
    output reg s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [31:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output reg s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    output reg interruptOutN, // Interrupt output, active low
    output reg wakeUp, // Wake-up request in low-power modes
    output reg pullUpEn, // Pull-up current source on
    output reg pullDownEn, // Pull-down current source on
    output reg failOutputEn, // Fail output function available
    output reg gpioFuncEn, // GPIO function available
    output reg measureRoute // Measurement path to GPIO pin
);

    // =============================================================
    // Filter state machine codes
    localparam [1:0] F_IDLE = 2'b01;
    localparam [1:0] F_COUNT = 2'b10;

    // Decode: mode is one in which the interrupt is signalled
    function activeMode;
        input [2:0] m;
        begin
            activeMode = (m == `MODE_NORMAL) || (m == `MODE_STOP);
        end
    endfunction

    // =============================================================
    // Registers
    reg [5:0] wakeControlReg; // En, cyclic, gpio wake, measure, only, fail test
    reg [1:0] pullConfigReg;
    reg pinWakeEventFlag;
    reg gpioWakeEventFlag;
    reg inputLevelStatus;
    reg cmdFailFlag;
    reg [2:0] mode;
    reg [2:0] sync1;
    reg [2:0] sync2; // Pin, gpio, switch after two flops
    reg cycSample;
    reg cycValid;
    reg swPrev;
    reg [15:0] intCnt;
    reg intGap;
    reg awHeld;
    reg wHeld;
    reg [31:0] awAddr;
    reg [31:0] wData;
    reg [3:0] wStrb;

    wire measure = wakeControlReg[`BIT_MEASURE];
    wire cyclic = wakeControlReg[`BIT_CYCLIC];
    wire wakeOn = wakeControlReg[`BIT_WAKE_EN] & ~measure; // see R6 see R16 see R17
    wire gpioWakeOn = wakeControlReg[`BIT_GPIO_WAKE] & ~measure; // see R15
    wire [1:0] qual;
    wire pinEvent;
    wire gpioEvent;
    wire anyEvent;
    wire wrGo = (awHeld | s_axi_awvalid) & (wHeld | s_axi_wvalid) & ~s_axi_bvalid;
    wire [31:0] wrAddr = awHeld ? awAddr : s_axi_awaddr;
    wire [31:0] wrData = wHeld ? wData : s_axi_wdata;
    wire [3:0] wrStrb = wHeld ? wStrb : s_axi_wstrb;
    wire wrMapped = (wrAddr[31:5] == 27'h0) && (wrAddr[4:2] <= 3'h5);
    // Two-flop synchroniser for the asynchronous pin inputs
    always @(posedge mclk) begin
        if (reset) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end else begin
            sync1 <= {highSideSwitch, gpioPin, hvWakePin};
            sync2 <= sync1;
        end
    end

    // =============================================================
    // Edge filters, one each for the wake pin and the GPIO pin; the switch input is not filtered
    // Restartable counter: any crossing restarts, full count qualifies
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : filt
            reg [1:0] st;
            reg [15:0] cnt;
            reg q;
            reg stb; // Qualified level
            always @(posedge mclk) begin
                if (reset) begin
                    st <= F_IDLE;
                    cnt <= 16'h0;
                    stb <= 1'b0;
                    q <= 1'b0;
                end else begin
                    q <= 1'b0;
                    case (st)
                        F_IDLE: begin
                            if (sync2[gi] != stb) begin // see R1 see R5
                                st <= F_COUNT;
                                cnt <= 16'h1;
                            end
                        end
                        F_COUNT: begin
                            if (sync2[gi] == stb) begin // see R5 see R21
                                st <= F_IDLE;
                                cnt <= 16'h0;
                            end else if (cnt >= FILTER_CYCLES[15:0]) begin // see R4 see R10
                                st <= F_IDLE;
                                cnt <= 16'h0;
                                stb <= sync2[gi];
                                q <= 1'b1;
                            end else begin
                                cnt <= cnt + 16'h1;
                            end
                        end
                        default: begin
                            st <= F_IDLE;
                            cnt <= 16'h0;
                        end
                    endcase
                end
            end
            assign qual[gi] = q;
        end
    endgenerate

    // =============================================================
    // Cyclic sense: sample at end of switch on-time, compare with previous
    reg cycEvent;
    always @(posedge mclk) begin
        if (reset) begin
            swPrev <= 1'b0;
            cycSample <= 1'b0;
            cycValid <= 1'b0;
            cycEvent <= 1'b0;
        end else begin
            swPrev <= sync2[2];
            cycEvent <= 1'b0;
            if (!cyclic || measure) begin
                cycValid <= 1'b0;
            end else if (swPrev && !sync2[2]) begin // see R13 see R14
                cycSample <= sync2[0];
                cycValid <= 1'b1;
                cycEvent <= cycValid && (sync2[0] != cycSample); // see R13
            end
        end
    end

    // Static sense uses the filter, cyclic sense the sampler
    assign pinEvent = wakeOn & (cyclic ? cycEvent : qual[0]); // see R3
    assign gpioEvent = gpioWakeOn & qual[1]; // see R10
    assign anyEvent = pinEvent | gpioEvent;

    // =============================================================
    // Interrupt pulse and minimum gap
    always @(posedge mclk) begin
        if (reset) begin
            interruptOutN <= 1'b1;
            intCnt <= 16'h0;
            intGap <= 1'b0;
        end else if (intCnt != 16'h0) begin
            intCnt <= intCnt - 16'h1;
            if (intCnt == 16'h1) begin
                if (!intGap) begin
                    interruptOutN <= 1'b1; // see R20
                    intGap <= 1'b1;
                    intCnt <= INT_CYCLES[15:0];
                end else begin
                    intGap <= 1'b0;
                end
            end
        end else if (anyEvent && activeMode(mode)) begin // see R2
            interruptOutN <= 1'b0; // see R20
            intCnt <= INT_CYCLES[15:0];
        end
    end

    // Wake-up in low-power modes
    always @(posedge mclk) begin
        if (reset) begin
            wakeUp <= 1'b0;
        end else begin
            wakeUp <= anyEvent &&
                ((mode == `MODE_SLEEP) || (mode == `MODE_FAILSAFE)); // see R2
        end
    end

    // =============================================================
    // Pull sources and function gating
    always @(posedge mclk) begin
        if (reset) begin
            pullUpEn <= 1'b0;
            pullDownEn <= 1'b0;
            failOutputEn <= 1'b1;
            gpioFuncEn <= 1'b1;
            measureRoute <= 1'b0;
        end else begin
            pullUpEn <= ~measure & ((pullConfigReg == 2'h2) ||
                ((pullConfigReg == 2'h3) & sync2[0])); // see R11 see R12 see R16
            pullDownEn <= ~measure & ((pullConfigReg == 2'h1) ||
                ((pullConfigReg == 2'h3) & ~sync2[0])); // see R11 see R12 see R16
            failOutputEn <= ~measure; // see R15
            gpioFuncEn <= ~measure; // see R15
            measureRoute <= measure;
        end
    end

    // =============================================================
    // Status flags and level status; hardware set wins over clear
    wire clrFirst = wrGo && wrMapped && (wrAddr[4:0] == {1'b0, `OFS_WAKE_STATUS_FIRST}) && wrStrb[0];
    wire clrSecond = wrGo && wrMapped && (wrAddr[4:0] == {1'b0, `OFS_WAKE_STATUS_SECOND}) && wrStrb[0];
    always @(posedge mclk) begin
        if (reset) begin
            pinWakeEventFlag <= 1'b0;
            gpioWakeEventFlag <= 1'b0;
            inputLevelStatus <= 1'b0;
        end else begin
            if (pinEvent) begin
                pinWakeEventFlag <= 1'b1; // see R7 see R18
            end else if (clrFirst && wrData[0]) begin
                pinWakeEventFlag <= 1'b0;
            end
            if (gpioEvent) begin
                gpioWakeEventFlag <= 1'b1; // see R10
            end else if (clrSecond && wrData[0]) begin
                gpioWakeEventFlag <= 1'b0;
            end
            if (measure) begin
                inputLevelStatus <= 1'b0; // see R18
            end else if (cyclic) begin
                inputLevelStatus <= cycSample; // see R9
            end else if (activeMode(mode) || (mode == `MODE_INIT)) begin
                inputLevelStatus <= sync2[0]; // see R8
            end
        end
    end

    // =============================================================
    // AXI4-Lite write channel and register writes
    always @(posedge mclk) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 32'h0;
            wData <= 32'h0;
            wStrb <= 4'h0;
            wakeControlReg <= `RST_WAKE_CONTROL;
            pullConfigReg <= `RST_PULL_CONFIG;
            mode <= `RST_MODE;
            cmdFailFlag <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (awHeld && wHeld && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrMapped ? 2'h0 : 2'h2;
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                if (wrMapped && wrStrb[0]) begin
                    // Settings stored even while measurement is on
                    if (wrAddr[4:0] == {1'b0, `OFS_WAKE_CONTROL}) begin
                        wakeControlReg <= wrData[5:0]; // see R17
                    end
                    if (wrAddr[4:0] == {1'b0, `OFS_PULL_CONFIG}) begin
                        pullConfigReg <= wrData[1:0]; // see R17
                    end
                    if (wrAddr[4:0] == `OFS_MODE_CTRL) begin
                        if ((wrData[2:0] == `MODE_SLEEP) && measure &&
                            wakeControlReg[`BIT_ONLY_SOURCE]) begin
                            mode <= `MODE_RESTART; // see R19
                            cmdFailFlag <= 1'b1; // see R19
                        end else begin
                            mode <= wrData[2:0];
                        end
                        if (wrData[`BIT_CMD_FAIL]) begin
                            cmdFailFlag <= 1'b0;
                        end
                    end
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // =============================================================
    // AXI4-Lite read channel
    always @(posedge mclk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0;
            if (s_axi_araddr[31:5] != 27'h0) begin
                s_axi_rresp <= 2'h2;
            end else begin
                case (s_axi_araddr[4:0])
                    {1'b0, `OFS_WAKE_CONTROL}: s_axi_rdata <= {26'h0, wakeControlReg};
                    {1'b0, `OFS_PULL_CONFIG}: s_axi_rdata <= {30'h0, pullConfigReg};
                    {1'b0, `OFS_WAKE_STATUS_FIRST}: s_axi_rdata <= {31'h0, pinWakeEventFlag};
                    {1'b0, `OFS_WAKE_STATUS_SECOND}: s_axi_rdata <= {31'h0, gpioWakeEventFlag};
                    `OFS_LEVEL_STATUS: s_axi_rdata <= {31'h0, inputLevelStatus};
                    `OFS_MODE_CTRL: s_axi_rdata <= {23'h0, cmdFailFlag, 5'h0, mode};
                    default: s_axi_rresp <= 2'h2;
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule
`default_nettype wire

/* core/hv_wake_map.vh */
// Constants for the high-voltage wake input logic: register offsets,
// field positions, reset values and timing figures.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef HV_WAKE_MAP_VH
`define HV_WAKE_MAP_VH

// =============================================================
// Register byte offsets
`define OFS_WAKE_CONTROL 4'h0
`define OFS_PULL_CONFIG 4'h4
`define OFS_WAKE_STATUS_FIRST 4'h8
`define OFS_WAKE_STATUS_SECOND 4'hc
// Level status and mode/command register share the upper decode
`define OFS_LEVEL_STATUS 5'h10
`define OFS_MODE_CTRL 5'h14

// =============================================================
// Field positions
`define BIT_WAKE_EN 0
`define BIT_CYCLIC 1
`define BIT_GPIO_WAKE 2
`define BIT_MEASURE 3
`define BIT_ONLY_SOURCE 4
`define BIT_FAIL_TEST 5
`define BIT_CMD_FAIL 8
`define BIT_RESTART 9

// =============================================================
// Mode encodings (three bits)
`define MODE_NORMAL 3'h0
`define MODE_STOP 3'h1
`define MODE_SLEEP 3'h2
`define MODE_FAILSAFE 3'h3
`define MODE_INIT 3'h4
`define MODE_RESTART 3'h5

// =============================================================
// Reset values
`define RST_WAKE_CONTROL 6'h01
`define RST_PULL_CONFIG 2'h0
`define RST_MODE 3'h4

// =============================================================
// Timing: figures in ns, counts derived from the 10 ns clock period
`define CLK_PERIOD_NS 10
`define WAKE_FILTER_TIME_NS 16000
`define WAKE_FILTER_CYCLES (`WAKE_FILTER_TIME_NS / `CLK_PERIOD_NS)
`define INT_PULSE_TIME_NS 100000
`define INT_PULSE_CYCLES (`INT_PULSE_TIME_NS / `CLK_PERIOD_NS)

`endif

/* testbench/hv_line_model.sv */
// Model of the high-voltage line that faces the wake pin.
// Assumes the bench chooses when the outside source drives the line.
`timescale 1ns/1ps
`default_nettype none
module hv_line_model (
    input wire logic mclk, // System clock
    input wire logic drive, // Outside source drives the line
    input wire logic level, // Level of the outside source
    input wire logic pullUpEn, // Pull-up current source on
    input wire logic pullDownEn, // Pull-down current source on
    output logic pin // Level seen by the comparator
);
    logic wander = 1'h0;
    // An open line with no current source drifts every cycle
    always @(posedge mclk) begin
        wander <= ~wander;
    end
    // A released line follows whichever current source is on
    always @* begin
        if (drive) begin
            pin = level;
        end else if (pullUpEn) begin
            pin = 1'h1;
        end else if (pullDownEn) begin
            pin = 1'h0;
        end else begin
            pin = wander;
        end
    end
endmodule
`default_nettype wire

/* testbench/hv_wake_input_logic_chk.sv */
// Concurrent checks on the ports of the wake input block.
// Assumes one clock, synchronous active-high reset, bound from the bench.
`timescale 1ns/1ps
`default_nettype none
module hv_wake_input_logic_chk #(
    parameter int INT_CYCLES = 8
) (
    input wire mclk, // System clock
    input wire reset, // Synchronous reset
    input wire s_axi_awvalid, // Write address valid
    input wire s_axi_awready, // Write address ready
    input wire s_axi_wvalid, // Write data valid
    input wire s_axi_wready, // Write data ready
    input wire s_axi_bvalid, // Write response valid
    input wire s_axi_arvalid, // Read address valid
    input wire s_axi_arready, // Read address ready
    input wire s_axi_rvalid, // Read data valid
    input wire interruptOutN, // Interrupt output
    input wire wakeUp, // Wake-up pulse
    input wire pullUpEn, // Pull-up on
    input wire pullDownEn, // Pull-down on
    input wire failOutputEn, // Fail output available
    input wire gpioFuncEn, // GPIO function available
    input wire measureRoute // Measurement path on
);
    logic [15:0] lowCnt;
    logic [15:0] highCnt;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // ====
    // Length of the current low and high stretch of the interrupt line
    always @(posedge mclk) begin
        if (reset) begin
            lowCnt <= 16'h0;
            highCnt <= 16'(INT_CYCLES);
        end else if (interruptOutN) begin
            lowCnt <= 16'h0;
            highCnt <= highCnt + 16'h1;
        end else begin
            lowCnt <= lowCnt + 16'h1;
            highCnt <= 16'h0;
        end
    end
    // ====
    // Assertions
    AST_PULL_EXCL: assert property (!(pullUpEn && pullDownEn))
        else $error("both current sources on");
    AST_MEAS_FUNC: assert property (measureRoute |-> !failOutputEn && !gpioFuncEn)
        else $error("functions left on in measurement");
    AST_MEAS_PULL: assert property (measureRoute |-> !pullUpEn && !pullDownEn)
        else $error("pull left on in measurement");
    AST_INT_WIDTH: assert property ($rose(interruptOutN) |-> lowCnt == INT_CYCLES)
        else $error("interrupt pulse width wrong");
    AST_INT_GAP: assert property ($fell(interruptOutN) |-> highCnt >= INT_CYCLES)
        else $error("interrupt gap too short");
    AST_WAKE_PULSE: assert property (wakeUp |=> !wakeUp)
        else $error("wake-up pulse too long");
    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    AST_RD_BUSY: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
        else $error("read address taken twice");
    // ====
    // Coverage of the main scenarios
    COV_INT: cover property ($fell(interruptOutN));
    COV_WAKE: cover property (wakeUp);
    COV_MEAS: cover property ($rose(measureRoute));
endmodule
`default_nettype wire

/* testbench/hv_wake_input_logic_tb.sv */
// Self-checking bench for the wake input block over AXI4-Lite.
// Assumes the map header is on the include path and short filter counts.
`timescale 1ns/1ps
`default_nettype none
`include "hv_wake_map.vh"
module hv_wake_input_logic_tb;
    localparam int FILT = 4;
    localparam int INTC = 8;
    typedef struct packed {logic [1:0] sel; logic lvl; logic up; logic dn;} pull_row_t;
    pull_row_t rows [5] = '{'{2'h0, 1'h1, 1'h0, 1'h0}, '{2'h1, 1'h1, 1'h0, 1'h1},
        '{2'h2, 1'h0, 1'h1, 1'h0}, '{2'h3, 1'h1, 1'h1, 1'h0}, '{2'h3, 1'h0, 1'h0, 1'h1}};
    logic mclk = 1'h0;
    logic reset = 1'h1;
    logic hvWakePin, pinLevel = 1'h0, pinDrive = 1'h1, gpioPin = 1'h0, highSideSwitch = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic interruptOutN, wakeUp, pullUpEn, pullDownEn, failOutputEn, gpioFuncEn, measureRoute;
    logic intPrev = 1'h1;
    logic [31:0] rd;
    int fails = 0, compares = 0, cycles = 0, intFalls = 0, wakes = 0, m, k, f0, w0;
    always #5 mclk = ~mclk;
    hv_wake_input_logic #(.FILTER_CYCLES(FILT), .INT_CYCLES(INTC)) dut (.*);
    hv_line_model line (.mclk(mclk), .drive(pinDrive), .level(pinLevel), .pullUpEn(pullUpEn),
        .pullDownEn(pullDownEn), .pin(hvWakePin));
    // Count interrupt pulses and wake-ups; cut a hang short
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        intPrev <= interruptOutN;
        if (intPrev === 1'h1 && interruptOutN === 1'h0) intFalls <= intFalls + 1;
        if (wakeUp === 1'h1) wakes <= wakes + 1;
        if (cycles == 6000) begin
            fails++;
            report_and_stop();
        end
    end
    // ====
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axw(input logic [31:0] a, input logic [31:0] d);
        logic da, dw, db;
        int n;
        db = 1'h0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!db && n < 50) begin
            @(negedge mclk);
            da = s_axi_awvalid && s_axi_awready;
            dw = s_axi_wvalid && s_axi_wready;
            db = s_axi_bvalid;
            @(posedge mclk);
            if (da) s_axi_awvalid <= 1'h0;
            if (dw) s_axi_wvalid <= 1'h0;
            n++;
        end
        if (!db) fails++;
    endtask
    task automatic axr(input logic [31:0] a);
        logic da, dr;
        int n;
        dr = 1'h0;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        while (!dr && n < 50) begin
            @(negedge mclk);
            da = s_axi_arvalid && s_axi_arready;
            dr = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge mclk);
            if (da) s_axi_arvalid <= 1'h0;
            n++;
        end
        if (!dr) fails++;
    endtask
    task automatic setpin(input logic v);
        pinLevel <= v;
        repeat (30) @(posedge mclk);
    endtask
    task automatic hs_window();
        highSideSwitch <= 1'h1;
        repeat (4) @(posedge mclk);
        highSideSwitch <= 1'h0;
        repeat (10) @(posedge mclk);
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ====
    // Main sequence
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'h0;
        @(posedge mclk);
        chk("intOut", 32'h1, interruptOutN);
        axr(`OFS_WAKE_CONTROL);
        chk("ctrl", `RST_WAKE_CONTROL, rd);
        axr(`OFS_MODE_CTRL);
        chk("mode", `RST_MODE, rd);
        axr(32'h40);
        chk("badResp", 32'h2, rsp);
        // Pull selection table, live level in Init
        foreach (rows[i]) begin
            setpin(rows[i].lvl);
            axw(`OFS_PULL_CONFIG, rows[i].sel);
            repeat (3) @(posedge mclk);
            chk("pullUp", rows[i].up, pullUpEn);
            chk("pullDn", rows[i].dn, pullDownEn);
            axr(`OFS_LEVEL_STATUS);
            chk("level", rows[i].lvl, rd);
        end
        axw(`OFS_WAKE_STATUS_FIRST, 32'h1);
        // Normal, Stop, Sleep and Fail-Safe modes, alternating edges
        for (m = 0; m < 4; m++) begin
            axw(`OFS_MODE_CTRL, m);
            f0 = intFalls;
            w0 = wakes;
            setpin(~pinLevel);
            chk("intFalls", m < 2, intFalls - f0);
            chk("wakes", m >= 2, wakes - w0);
            axr(`OFS_WAKE_STATUS_FIRST);
            chk("wakeFlag", 32'h1, rd);
            axw(`OFS_WAKE_STATUS_FIRST, 32'h1);
        end
        // Pulses just under and just over the filter count
        axw(`OFS_MODE_CTRL, `MODE_NORMAL);
        for (k = 0; k < 2; k++) begin
            pinLevel <= ~pinLevel;
            repeat (k ? FILT + 1 : FILT - 1) @(posedge mclk);
            setpin(~pinLevel);
            axr(`OFS_WAKE_STATUS_FIRST);
            chk("filterFlag", k, rd);
            axw(`OFS_WAKE_STATUS_FIRST, 32'h1);
        end
        axw(`OFS_WAKE_CONTROL, 32'h0);
        setpin(~pinLevel);
        axr(`OFS_WAKE_STATUS_FIRST);
        chk("disabledFlag", 32'h0, rd);
        axw(`OFS_WAKE_CONTROL, 32'h5);
        gpioPin <= 1'h1;
        repeat (30) @(posedge mclk);
        axr(`OFS_WAKE_STATUS_SECOND);
        chk("gpioFlag", 32'h1, rd);
        // Cyclic sense: level only taken in switch windows
        axw(`OFS_WAKE_CONTROL, 32'h3);
        hs_window();
        f0 = pinLevel;
        setpin(~pinLevel);
        axr(`OFS_LEVEL_STATUS);
        chk("heldLevel", f0, rd);
        axr(`OFS_WAKE_STATUS_FIRST);
        chk("noWindowFlag", 32'h0, rd);
        hs_window();
        axr(`OFS_LEVEL_STATUS);
        chk("newLevel", ~f0 & 32'h1, rd);
        axr(`OFS_WAKE_STATUS_FIRST);
        chk("cyclicFlag", 32'h1, rd);
        axw(`OFS_WAKE_STATUS_FIRST, 32'h1);
        // Measurement pass-through
        axw(`OFS_WAKE_CONTROL, 32'h9);
        axw(`OFS_PULL_CONFIG, 32'h2);
        repeat (3) @(posedge mclk);
        chk("measRoute", 32'h1, measureRoute);
        chk("failOut", 32'h0, failOutputEn);
        chk("gpioFunc", 32'h0, gpioFuncEn);
        chk("measPullUp", 32'h0, pullUpEn);
        axr(`OFS_PULL_CONFIG);
        chk("measPullReg", 32'h2, rd);
        setpin(1'h0);
        setpin(1'h1);
        axr(`OFS_WAKE_STATUS_FIRST);
        chk("measFlag", 32'h0, rd);
        axr(`OFS_LEVEL_STATUS);
        chk("measLevel", 32'h0, rd);
        axw(`OFS_WAKE_CONTROL, 32'h19);
        axw(`OFS_MODE_CTRL, `MODE_SLEEP);
        axr(`OFS_MODE_CTRL);
        chk("sleepRefused", 32'h105, rd);
        report_and_stop();
    end
endmodule
bind hv_wake_input_logic hv_wake_input_logic_chk #(.INT_CYCLES(INT_CYCLES)) chk (.*);
`default_nettype wire
